// ### logic/rfam_defs.svh
// Constants for the register file address map block.
`ifndef RFAM_DEFS_SVH
`define RFAM_DEFS_SVH

// ----------------------------------------------------------------------
// Control register addresses
// ----------------------------------------------------------------------
`define RFAM_ADDR_STATUS     12'hffc
`define RFAM_ADDR_BANK       12'hffd
`define RFAM_ADDR_SP_HIGH    12'hffe
`define RFAM_ADDR_SP_LOW     12'hfff
`define RFAM_CTRL_BASE       12'hf00
`define RFAM_STACK_TOP       12'heff
`define RFAM_ADDR_ZERO       12'h000

// ----------------------------------------------------------------------
// Opcodes and vectors
// ----------------------------------------------------------------------
`define RFAM_OP_PREFIX       8'h1f
`define RFAM_OP_SET_BANK     8'h01
`define RFAM_OP_DEC_REG      8'h30
`define RFAM_OP_DEC_IND      8'h31
`define RFAM_OP_JP_PAIR      8'hc4
`define RFAM_OP_NOP          8'h0f
`define RFAM_OP_LOAD         8'he4
`define RFAM_VEC_RESET_HI    16'h0002
`define RFAM_VEC_RESET_LO    16'h0003
`define RFAM_VEC_INT_BASE    16'h0008

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define RFAM_RST_BYTE        8'h00
`define RFAM_RST_WORD        16'h0000
`define RFAM_NIB_ZERO        4'h0
`define RFAM_ONE12           12'h001

`endif

// ### logic/rfam_mem.sv
// Byte-wide general-purpose register storage with registered read data.
`timescale 1ns/1ns
module rfam_mem #(
	parameter int AW = 12
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata
);
	logic [7:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : rfam_mem

// ### logic/rfam_pkg.sv
// Types shared by the register file address map block.
package rfam_pkg;

	// ------------------------------------------------------------------
	// Addressing modes of a register operand
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		RFAM_MODE_LINEAR  = 2'h0,
		RFAM_MODE_PAGE    = 2'h1,
		RFAM_MODE_WORKING = 2'h2,
		RFAM_MODE_STACK   = 2'h3
	} rfam_mode_t;

	// ------------------------------------------------------------------
	// Register access request from the execution unit
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        word;
		rfam_mode_t  mode;
		logic [11:0] addr;
		logic [15:0] wdata;
	} rfam_req_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] rdata;
	} rfam_rsp_t;

	// ------------------------------------------------------------------
	// Decoder output
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		RFAM_DEC_OTHER    = 4'h0,
		RFAM_DEC_SET_BANK = 4'h1,
		RFAM_DEC_DEC_REG  = 4'h2,
		RFAM_DEC_DEC_IND  = 4'h3,
		RFAM_DEC_JP_PAIR  = 4'h4,
		RFAM_DEC_NOP      = 4'h5,
		RFAM_DEC_LOAD     = 4'h6,
		RFAM_DEC_ALT      = 4'h7
	} rfam_dec_t;

	typedef enum logic [2:0] {
		RFAM_ST_VEC_HI = 3'b001,
		RFAM_ST_VEC_LO = 3'b010,
		RFAM_ST_RUN    = 3'b100
	} rfam_state_t;

endpackage : rfam_pkg

// ### logic/rfam_top.sv
// Register file address map, control registers, decoder and reset fetch.
// Operation
// [RULE_01] Prefix byte 1FH selects the second opcode map for the next byte.
// [RULE_02] Opcodes: set bank 01, dec 30, dec indirect 31, jp pair C4, nop 0F.
// [RULE_03] Working-to-register loads decode as the general load opcode E4.
// [RULE_04] Stack pointer low byte at FFFH, high byte at FFEH.
// [RULE_05] Bank pointer at FFDH.
// [RULE_06] Condition status at FFCH.
// [RULE_07] Stack address is high-byte low nibble above low byte.
// [RULE_08] Stack accesses hit register space; origin anywhere 000H to EFFH.
// [RULE_09] Reset fetches vector from 0002H (high) and 0003H (low) into PC.
// [RULE_10] Interrupt vector table starts at program address 0008H.
// [RULE_11] Register space spans at most 4096 byte registers.
// [RULE_12] F00H to FFFH hold control registers; rest is general storage. Here storage is backed only below GP_LIMIT (800H).
// [RULE_13] Sources are read and destinations are written.
// [RULE_14] Unimplemented addresses read anything; writes change nothing.
// [RULE_15] Addressable linear 12-bit, paged 8-bit, and working 4-bit.
// [RULE_16] Page addresses are bank low nibble above the 8-bit operand.
// [RULE_17] 12-bit operands reach any register regardless of bank pointer.
// [RULE_18] Extended instructions form full 12-bit addresses across pages.
// [RULE_19] Set-bank op and loads to the bank address change the page.
// [RULE_20] Bank high nibble picks working group, low nibble picks page.
// [RULE_21] Working address is page, group, then 4-bit operand.
// [RULE_22] Register pairs are big-endian, high byte at the even address. Here the low byte is read from a second copy only word writes update.
// [RULE_23] Stack high byte upper nibble is unused and reads as zero.
`timescale 1ns/1ns
`include "rfam_defs.svh"
module rfam_top #(
	parameter int          GP_AW    = 11,
	parameter logic [11:0] GP_LIMIT = 12'h800
) (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire rfam_pkg::rfam_req_t req,
	output rfam_pkg::rfam_rsp_t      rsp,
	input  wire logic [7:0]          opcode,
	input  wire logic                opcode_valid,
	output rfam_pkg::rfam_dec_t      dec_op,
	output logic                     dec_valid,
	output logic                     alt_map,
	output logic [15:0]              pm_addr,
	output logic                     pm_rd,
	input  wire logic [7:0]          pm_data,
	output logic [15:0]              pc,
	output logic                     run,
	output logic [15:0]              int_vec_base,
	output logic [11:0]              stack_addr,
	output logic [7:0]               bank_pointer,
	output logic [7:0]               condition_status
);
	import rfam_pkg::*;

	// ------------------------------------------------------------------
	// Address formation
	// ------------------------------------------------------------------
	logic [7:0]  bank_reg;
	logic [7:0]  status_reg;
	logic [3:0]  sph_reg;
	logic [7:0]  spl_reg;
	logic [11:0] full_addr; // RULE_11
	logic [11:0] addr_hi;
	logic [11:0] addr_lo;
	logic [11:0] stack_now;

	assign stack_now = {sph_reg, spl_reg}; // RULE_07
	// Pair operands address the high byte at the operand address and the low byte one above it.
	always_comb begin
		case (req.mode) // RULE_15
			RFAM_MODE_LINEAR:  full_addr = req.addr; // RULE_17 RULE_18
			RFAM_MODE_PAGE:    full_addr = {bank_reg[3:0], req.addr[7:0]}; // RULE_16
			RFAM_MODE_WORKING: full_addr = {bank_reg[3:0], bank_reg[7:4],
				req.addr[3:0]}; // RULE_21
			RFAM_MODE_STACK:   full_addr = stack_now; // RULE_08
			default:           full_addr = req.addr;
		endcase
	end
	assign addr_hi = full_addr; // RULE_22
	assign addr_lo = full_addr + `RFAM_ONE12; // RULE_22

	// ------------------------------------------------------------------
	// Decode of target regions
	// ------------------------------------------------------------------
	logic wr;
	logic hit_status_hi;
	logic hit_bank_hi;
	logic hit_sph_hi;
	logic hit_spl_hi;
	logic hit_status_lo;
	logic hit_bank_lo;
	logic hit_sph_lo;
	logic hit_spl_lo;
	logic gp_hi;
	logic gp_lo;

	assign wr = req.valid && req.write; // RULE_13
	assign hit_status_hi = addr_hi == `RFAM_ADDR_STATUS; // RULE_06
	assign hit_bank_hi   = addr_hi == `RFAM_ADDR_BANK; // RULE_05
	assign hit_sph_hi    = addr_hi == `RFAM_ADDR_SP_HIGH; // RULE_04
	assign hit_spl_hi    = addr_hi == `RFAM_ADDR_SP_LOW; // RULE_04
	assign hit_status_lo = req.word && addr_lo == `RFAM_ADDR_STATUS;
	assign hit_bank_lo   = req.word && addr_lo == `RFAM_ADDR_BANK;
	assign hit_sph_lo    = req.word && addr_lo == `RFAM_ADDR_SP_HIGH;
	assign hit_spl_lo    = req.word && addr_lo == `RFAM_ADDR_SP_LOW;
	// Only the low part of space is backed; all else but the four control registers ignores writes.
	assign gp_hi = addr_hi < GP_LIMIT && addr_hi < `RFAM_CTRL_BASE; // RULE_12
	assign gp_lo = addr_lo < GP_LIMIT && addr_lo < `RFAM_CTRL_BASE; // RULE_14

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	logic [7:0] wb_hi;
	logic [7:0] wb_lo;
	logic       alt_pending;
	logic       setbank_go;
	logic [7:0] bank_next;
	logic [7:0] status_next;
	logic [3:0] sph_next;
	logic [7:0] spl_next;

	assign wb_hi = req.word ? req.wdata[15:8] : req.wdata[7:0];
	assign wb_lo = req.wdata[7:0];
	assign setbank_go = opcode_valid && !alt_pending
		&& opcode == `RFAM_OP_SET_BANK;
	// The set-bank op loads its operand byte from the write data lane.
	assign bank_next = (wr && hit_bank_hi) ? wb_hi :
		(wr && hit_bank_lo) ? wb_lo :
		setbank_go ? req.wdata[7:0] : bank_reg; // RULE_19 RULE_20
	assign status_next = (wr && hit_status_hi) ? wb_hi :
		(wr && hit_status_lo) ? wb_lo : status_reg;
	assign sph_next = (wr && hit_sph_hi) ? wb_hi[3:0] :
		(wr && hit_sph_lo) ? wb_lo[3:0] : sph_reg; // RULE_23
	assign spl_next = (wr && hit_spl_hi) ? wb_hi :
		(wr && hit_spl_lo) ? wb_lo : spl_reg;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			bank_reg   <= `RFAM_RST_BYTE;
			status_reg <= `RFAM_RST_BYTE;
			sph_reg    <= `RFAM_NIB_ZERO;
			spl_reg    <= `RFAM_RST_BYTE;
		end else begin
			bank_reg   <= bank_next;
			status_reg <= status_next;
			sph_reg    <= sph_next;
			spl_reg    <= spl_next;
		end
	end

	// ------------------------------------------------------------------
	// General-purpose storage, one bank per byte of a pair
	// ------------------------------------------------------------------
	logic [7:0] mem_rd_hi;
	logic [7:0] mem_rd_lo;
	logic [7:0] ctl_rd_hi;
	logic [7:0] ctl_rd_lo;
	logic [7:0] ctl_hi_reg;
	logic [7:0] ctl_lo_reg;
	logic       gp_hi_reg;
	logic       gp_lo_reg;
	logic       rd_pend_reg;
	logic       word_reg;

	// Two ports of one array would be cleaner, but a second copy keeps
	// the memory single-ported and lets a pair be read in one cycle.
	rfam_mem #(.AW(GP_AW)) u_mem_hi (
		.clk   (clk),
		.we    (wr && gp_hi), // RULE_14
		.waddr (addr_hi[GP_AW-1:0]),
		.wdata (wb_hi),
		.raddr (addr_hi[GP_AW-1:0]),
		.rdata (mem_rd_hi)
	);
	rfam_mem #(.AW(GP_AW)) u_mem_lo (
		.clk   (clk),
		.we    (wr && req.word && gp_lo), // RULE_22
		.waddr (addr_lo[GP_AW-1:0]),
		.wdata (wb_lo),
		.raddr (addr_lo[GP_AW-1:0]),
		.rdata (mem_rd_lo)
	);
	// The two copies can disagree; a byte write to the low copy's address
	// is mirrored through the high copy only, so pairs read from memory
	// take each byte from the copy addressed at its own location.

	assign ctl_rd_hi = hit_status_hi ? status_reg :
		hit_bank_hi ? bank_reg :
		hit_sph_hi ? {`RFAM_NIB_ZERO, sph_reg} :
		hit_spl_hi ? spl_reg : `RFAM_RST_BYTE;
	assign ctl_rd_lo = hit_status_lo ? status_reg :
		hit_bank_lo ? bank_reg :
		hit_sph_lo ? {`RFAM_NIB_ZERO, sph_reg} :
		hit_spl_lo ? spl_reg : `RFAM_RST_BYTE;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_pend_reg <= 1'b0;
			word_reg    <= 1'b0;
			gp_hi_reg   <= 1'b0;
			gp_lo_reg   <= 1'b0;
			ctl_hi_reg  <= `RFAM_RST_BYTE;
			ctl_lo_reg  <= `RFAM_RST_BYTE;
		end else begin
			rd_pend_reg <= req.valid && !req.write; // RULE_13
			word_reg    <= req.word;
			gp_hi_reg   <= gp_hi;
			gp_lo_reg   <= gp_lo;
			ctl_hi_reg  <= ctl_rd_hi;
			ctl_lo_reg  <= ctl_rd_lo;
		end
	end

	logic [7:0] rd_hi;
	logic [7:0] rd_lo;
	assign rd_hi = gp_hi_reg ? mem_rd_hi : ctl_hi_reg;
	assign rd_lo = gp_lo_reg ? mem_rd_lo : ctl_lo_reg;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rsp <= '0;
		end else begin
			rsp.valid <= rd_pend_reg;
			rsp.rdata <= word_reg ? {rd_hi, rd_lo}
				: {`RFAM_RST_BYTE, rd_hi}; // RULE_22
		end
	end

	// ------------------------------------------------------------------
	// Opcode decoder
	// ------------------------------------------------------------------
	rfam_dec_t dec_next;

	always_comb begin
		case (opcode)
			`RFAM_OP_PREFIX:   dec_next = RFAM_DEC_ALT; // RULE_01
			`RFAM_OP_SET_BANK: dec_next = RFAM_DEC_SET_BANK; // RULE_02
			`RFAM_OP_DEC_REG:  dec_next = RFAM_DEC_DEC_REG; // RULE_02
			`RFAM_OP_DEC_IND:  dec_next = RFAM_DEC_DEC_IND; // RULE_02
			`RFAM_OP_JP_PAIR:  dec_next = RFAM_DEC_JP_PAIR; // RULE_02
			`RFAM_OP_NOP:      dec_next = RFAM_DEC_NOP; // RULE_02
			`RFAM_OP_LOAD:     dec_next = RFAM_DEC_LOAD; // RULE_03
			default:           dec_next = RFAM_DEC_OTHER;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			alt_pending <= 1'b0;
			alt_map     <= 1'b0;
			dec_op      <= RFAM_DEC_OTHER;
			dec_valid   <= 1'b0;
		end else begin
			dec_valid <= opcode_valid;
			if (opcode_valid) begin
				// The byte after a prefix comes from the second map.
				alt_pending <= !alt_pending && opcode == `RFAM_OP_PREFIX;
				alt_map     <= alt_pending; // RULE_01
				dec_op      <= alt_pending ? RFAM_DEC_OTHER : dec_next;
			end
		end
	end

	// ------------------------------------------------------------------
	// Reset vector fetch
	// ------------------------------------------------------------------
	rfam_state_t st_reg;
	logic [7:0]  vec_hi_reg;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_reg     <= RFAM_ST_VEC_HI;
			vec_hi_reg <= `RFAM_RST_BYTE;
			pc         <= `RFAM_RST_WORD;
			pm_addr    <= `RFAM_VEC_RESET_HI;
			pm_rd      <= 1'b1;
			run        <= 1'b0;
		end else begin
			case (st_reg)
				RFAM_ST_VEC_HI: begin
					vec_hi_reg <= pm_data; // RULE_09
					pm_addr    <= `RFAM_VEC_RESET_LO;
					st_reg     <= RFAM_ST_VEC_LO;
				end
				RFAM_ST_VEC_LO: begin
					pc     <= {vec_hi_reg, pm_data}; // RULE_09
					pm_rd  <= 1'b0;
					run    <= 1'b1;
					st_reg <= RFAM_ST_RUN;
				end
				RFAM_ST_RUN: begin
					st_reg <= RFAM_ST_RUN;
				end
				default: begin
					st_reg <= RFAM_ST_VEC_HI;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Exported state
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			int_vec_base     <= `RFAM_RST_WORD;
			stack_addr       <= `RFAM_ADDR_ZERO;
			bank_pointer     <= `RFAM_RST_BYTE;
			condition_status <= `RFAM_RST_BYTE;
		end else begin
			int_vec_base     <= `RFAM_VEC_INT_BASE; // RULE_10
			stack_addr       <= stack_now; // RULE_07
			bank_pointer     <= bank_reg;
			condition_status <= status_reg;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence vec_hi_s;
		run == 1'b0 && pm_addr == `RFAM_VEC_RESET_HI;
	endsequence
	sequence vec_lo_s;
		pm_addr == `RFAM_VEC_RESET_LO;
	endsequence

	reset_fetch_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
		$rose(rstn) ##0 vec_hi_s |=> vec_lo_s ##1 run)
		else $error("reset vector fetch order wrong");
	reset_pc_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
		$rose(run) |-> pc == {vec_hi_reg, $past(pm_data)})
		else $error("pc not loaded from vector");
	bank_write_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
		wr && !req.word && req.mode == RFAM_MODE_LINEAR
		&& req.addr == `RFAM_ADDR_BANK |=> bank_reg == $past(req.wdata[7:0]))
		else $error("bank pointer write lost");
	status_write_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
		wr && !req.word && req.mode == RFAM_MODE_LINEAR
		&& req.addr == `RFAM_ADDR_STATUS |=> status_reg == $past(req.wdata[7:0]))
		else $error("status write lost");
	stack_form_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
		##1 stack_addr == $past(stack_now))
		else $error("stack address mis-formed");
	page_form_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_16
		req.mode == RFAM_MODE_PAGE |-> full_addr[11:8] == bank_reg[3:0])
		else $error("page address mis-formed");
	work_form_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_21
		req.mode == RFAM_MODE_WORKING |-> full_addr[7:4] == bank_reg[7:4]
		&& full_addr[11:8] == bank_reg[3:0])
		else $error("working address mis-formed");
	alt_map_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
		opcode_valid && opcode == `RFAM_OP_PREFIX && !alt_pending
		##1 opcode_valid |=> alt_map)
		else $error("second map not selected");
	read_lat_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_13
		req.valid && !req.write |-> ##2 rsp.valid)
		else $error("read answer late");
endmodule : rfam_top

// ### verif/rfam_pm_model.sv
// Program memory model that answers the reset vector fetch of the block.
`timescale 1ns/1ns
module rfam_pm_model #(
	parameter logic [15:0] VEC = 16'h0a5c
) (
	input  wire logic        clk,
	input  wire logic [15:0] pm_addr,
	input  wire logic        pm_rd,
	output logic      [7:0]  pm_data
);
	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	logic [7:0] idle_reg = 8'h5a;

	// Outside a fetch the bus is not driven, so a changing pattern stands in.
	always @(posedge clk) begin
		idle_reg <= ~idle_reg;
	end

	always_comb begin
		if (pm_rd !== 1'b1) begin
			pm_data = idle_reg;
		end else if (pm_addr == 16'h0002) begin
			pm_data = VEC[15:8];
		end else if (pm_addr == 16'h0003) begin
			pm_data = VEC[7:0];
		end else begin
			pm_data = 8'hff;
		end
	end
endmodule : rfam_pm_model

// ### verif/rfam_top_tb.sv
// Self-checking testbench for the register file address map block.
`timescale 1ns/1ns
module rfam_top_tb;
	import rfam_pkg::*;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	localparam logic [15:0] VEC = 16'h0a5c;
	localparam logic [7:0]  OPS [6] = '{8'h01, 8'h30, 8'h31, 8'hc4,
		8'h0f, 8'he4};
	localparam rfam_dec_t   EXPS [6] = '{RFAM_DEC_SET_BANK,
		RFAM_DEC_DEC_REG, RFAM_DEC_DEC_IND, RFAM_DEC_JP_PAIR,
		RFAM_DEC_NOP, RFAM_DEC_LOAD};
	logic        clk;
	logic        rstn;
	rfam_req_t   req;
	rfam_rsp_t   rsp;
	logic [7:0]  opcode;
	logic        opcode_valid;
	rfam_dec_t   dec_op;
	logic        dec_valid;
	logic        alt_map;
	logic [15:0] pm_addr;
	logic        pm_rd;
	logic [7:0]  pm_data;
	logic [15:0] pc;
	logic        run;
	logic [15:0] int_vec_base;
	logic [11:0] stack_addr;
	logic [7:0]  bank_pointer;
	logic [7:0]  condition_status;
	int          error_cnt;
	int          compares;

	rfam_top i_dut (.clk(clk), .rstn(rstn), .req(req), .rsp(rsp),
		.opcode(opcode), .opcode_valid(opcode_valid), .dec_op(dec_op),
		.dec_valid(dec_valid), .alt_map(alt_map), .pm_addr(pm_addr),
		.pm_rd(pm_rd), .pm_data(pm_data), .pc(pc), .run(run),
		.int_vec_base(int_vec_base), .stack_addr(stack_addr),
		.bank_pointer(bank_pointer), .condition_status(condition_status));

	rfam_pm_model #(.VEC(VEC)) i_pm (.clk(clk), .pm_addr(pm_addr),
		.pm_rd(pm_rd), .pm_data(pm_data));

	always #50 clk = ~clk;

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic wd, input rfam_mode_t md,
			input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= {1'b1, wr, wd, md, a, d};
		@(posedge clk);
		req <= '0;
	endtask : bus

	task automatic wr8(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, RFAM_MODE_LINEAR, a, {8'h00, d});
	endtask : wr8

	// The answer is awaited under a bound so a silent design cannot hang.
	task automatic rd(input logic wd, input rfam_mode_t md,
			input logic [11:0] a, input logic [15:0] exp);
		int n;
		bus(1'b0, wd, md, a, 16'h0000);
		n = 0;
		while (n < 4) begin
			@(posedge clk);
			#1;
			n++;
			if (rsp.valid === 1'b1) break;
		end
		chk({15'h0000, rsp.valid}, 16'h0001);
		chk(rsp.rdata, exp);
	endtask : rd

	task automatic op(input logic [7:0] o, input logic [7:0] wd);
		@(posedge clk);
		opcode <= o;
		opcode_valid <= 1'b1;
		req.wdata <= {8'h00, wd};
		@(posedge clk);
		opcode_valid <= 1'b0;
		#1;
	endtask : op

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		chk(pc, VEC);
		chk({15'h0000, run}, 16'h0001);
		chk({15'h0000, pm_rd}, 16'h0000);
		chk(int_vec_base, 16'h0008);
		rd(1'b0, RFAM_MODE_LINEAR, 12'hffd, 16'h0000);
		rd(1'b0, RFAM_MODE_LINEAR, 12'hffc, 16'h0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_ctrl();
		wr8(12'hffc, 8'h5a);
		wr8(12'hffd, 8'hc3);
		wr8(12'hffe, 8'hf7);
		wr8(12'hfff, 8'h2e);
		@(posedge clk);
		#1;
		chk({8'h00, condition_status}, 16'h005a);
		chk({8'h00, bank_pointer}, 16'h00c3);
		chk({4'h0, stack_addr}, 16'h072e);
		rd(1'b0, RFAM_MODE_LINEAR, 12'hfff, 16'h002e);
		rd(1'b0, RFAM_MODE_LINEAR, 12'hffe, 16'h0007);
		rd(1'b1, RFAM_MODE_LINEAR, 12'hffe, 16'h072e);
		$display("test control registers done");
	endtask : t_ctrl

	task automatic t_modes();
		wr8(12'hffd, 8'h53);
		bus(1'b1, 1'b0, RFAM_MODE_PAGE, 12'h021, 16'h00a1);
		bus(1'b1, 1'b0, RFAM_MODE_WORKING, 12'h007, 16'h00b2);
		rd(1'b0, RFAM_MODE_LINEAR, 12'h321, 16'h00a1);
		rd(1'b0, RFAM_MODE_LINEAR, 12'h357, 16'h00b2);
		op(8'h01, 8'h14);
		@(posedge clk);
		#1;
		chk({8'h00, bank_pointer}, 16'h0014);
		bus(1'b1, 1'b0, RFAM_MODE_PAGE, 12'h021, 16'h00c4);
		rd(1'b0, RFAM_MODE_LINEAR, 12'h421, 16'h00c4);
		rd(1'b0, RFAM_MODE_LINEAR, 12'h321, 16'h00a1);
		bus(1'b1, 1'b1, RFAM_MODE_LINEAR, 12'h122, 16'h0001);
		rd(1'b1, RFAM_MODE_LINEAR, 12'h122, 16'h0001);
		$display("test addressing modes done");
	endtask : t_modes

	task automatic t_stack();
		wr8(12'hffe, 8'h02);
		wr8(12'hfff, 8'h40);
		bus(1'b1, 1'b0, RFAM_MODE_STACK, 12'h000, 16'h009e);
		rd(1'b0, RFAM_MODE_LINEAR, 12'h240, 16'h009e);
		rd(1'b0, RFAM_MODE_STACK, 12'h000, 16'h009e);
		$display("test stack done");
	endtask : t_stack

	// A write above the storage must not alias onto a lower address.
	task automatic t_refused();
		wr8(12'h100, 8'h11);
		wr8(12'h900, 8'h77);
		wr8(12'hf00, 8'h66);
		wr8(12'hffb, 8'h99);
		rd(1'b0, RFAM_MODE_LINEAR, 12'h100, 16'h0011);
		chk({8'h00, bank_pointer}, 16'h0014);
		chk({8'h00, condition_status}, 16'h005a);
		$display("test refused writes done");
	endtask : t_refused

	task automatic t_decode();
		for (int i = 0; i < 6; i++) begin
			op(OPS[i], 8'h14);
			chk({15'h0000, dec_valid}, 16'h0001);
			chk({12'h000, dec_op}, {12'h000, EXPS[i]});
		end
		op(8'h1f, 8'h14);
		chk({12'h000, dec_op}, {12'h000, RFAM_DEC_ALT});
		op(8'h30, 8'h14);
		chk({15'h0000, alt_map}, 16'h0001);
		op(8'h30, 8'h14);
		chk({15'h0000, alt_map}, 16'h0000);
		// Prefix and its opcode on consecutive cycles, with no gap.
		@(posedge clk);
		opcode <= 8'h1f;
		opcode_valid <= 1'b1;
		@(posedge clk);
		opcode <= 8'h0f;
		@(posedge clk);
		opcode_valid <= 1'b0;
		#1;
		chk({15'h0000, alt_map}, 16'h0001);
		chk({12'h000, dec_op}, {12'h000, RFAM_DEC_OTHER});
		$display("test decoder done");
	endtask : t_decode

	// ------------------------------------------------------------------
	// Sequence and verdict
	// ------------------------------------------------------------------
	task automatic final_report();
		$display("counts: compares=%0d mismatches=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		req = '0;
		opcode = 8'h00;
		opcode_valid = 1'b0;
		error_cnt = 0;
		compares = 0;
		repeat (15) @(posedge clk);
		#1;
		chk(pm_addr, 16'h0002);
		chk({15'h0000, pm_rd}, 16'h0001);
		@(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		t_reset();
		t_ctrl();
		t_modes();
		t_stack();
		t_refused();
		t_decode();
		final_report();
	end

	// The scenarios need about 120 cycles, so this bound is generous.
	initial begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		$display("watchdog expired");
		final_report();
	end
endmodule : rfam_top_tb
